// >>> include/cal5_regs_pkg.sv
// Constants for the channel-5 calibration and map checksum register slice.
// Assumes a host-side serial decoder presents word-wide register accesses.
// Function
// R1: Offset upper word at 23h, resets zero.
// R2: Offset low byte in 24h bits 15:8.
// R3: Lower words bits 7:0 read zero.
// R4: Gain upper word at 25h, resets 8000h.
// R5: Gain low byte in 26h bits 15:8.
// R6: Gain is unsigned fraction below 2.0.
// R7: Checksum at 3Eh read-only, resets zero; the code reads map_checksum_i live and does not reset it.
// R8: Host writes only zeros to 3Fh.
// R9: Result is offset-subtracted then gain-scaled.
package cal5_regs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [5:0]  ADDR_OFFSET_UPPER   = 6'h23;
	localparam logic [5:0]  ADDR_OFFSET_LOWER   = 6'h24;
	localparam logic [5:0]  ADDR_GAIN_UPPER     = 6'h25;
	localparam logic [5:0]  ADDR_GAIN_LOWER     = 6'h26;
	localparam logic [5:0]  ADDR_MAP_CHECKSUM   = 6'h3e;
	localparam logic [5:0]  ADDR_RESERVED_WORD  = 6'h3f;

	localparam logic [15:0] RST_OFFSET_UPPER    = 16'h0000;
	localparam logic [7:0]  RST_OFFSET_LOW      = 8'h00;
	localparam logic [15:0] RST_GAIN_UPPER      = 16'h8000;
	localparam logic [7:0]  RST_GAIN_LOW        = 8'h00;
	localparam logic [15:0] RST_RESERVED_WORD   = 16'h0000;
	localparam logic [7:0]  RESERVED_LOW_BITS   = 8'h00;

	// ****************************************
	// Datapath
	// ****************************************
	localparam int          COEF_W              = 24;
	localparam int          GAIN_FRAC_BITS      = 23;
	localparam logic [23:0] GAIN_UNITY          = 24'h800000;

endpackage

// >>> logic/cal5_corrector.sv
// Offset and gain correction of a 24-bit channel-5 result.
// Assumes sample valid pulses from the converter filter, same clock.
`timescale 1ns/1ps
module cal5_corrector
	import cal5_regs_pkg::*;
(
	input  wire logic               sys_clk_i,
	input  wire logic               rst_i,
	input  wire logic               sample_valid_i,
	input  wire logic signed [23:0] sample_i,
	input  wire logic signed [23:0] offset_i,
	input  wire logic        [23:0] gain_i,
	output logic                    result_valid_o,
	output logic signed      [23:0] result_o
);
	// ****************************************
	// Subtract, scale, saturate
	// ****************************************
	// Difference kept at 25 bits so the subtraction never wraps
	wire logic signed [24:0] diff      = 25'(sample_i) - 25'(offset_i);                      // see R9
	wire logic signed [49:0] product   = 50'(diff) * $signed({26'h0, gain_i});             // see R6
	wire logic signed [49:0] scaled    = product >>> GAIN_FRAC_BITS;                        // see R9
	wire logic               too_high  = scaled > 50'sh7fffff;
	wire logic               too_low   = scaled < -50'sh800000;
	wire logic signed [23:0] clipped   = too_high ? 24'sh7fffff :
					     too_low  ? 24'sh800000 : scaled[23:0];

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			result_valid_o <= 1'b0;
			result_o       <= '0;
		end else begin
			result_valid_o <= sample_valid_i;
			if (sample_valid_i) begin
				result_o <= clipped;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_unity_passthrough;
		@(posedge sys_clk_i) disable iff (rst_i)
		(sample_valid_i && gain_i == GAIN_UNITY && offset_i == 24'sh0)
			|=> (result_o == $past(sample_i));
	endproperty
	a_unity_passthrough: assert property (p_unity_passthrough) else $error("unity gain altered sample"); // see R9
endmodule // cal5_corrector

// >>> logic/cal5_regs.sv
// Channel-5 calibration words, map checksum and reserved word register slice.
// Assumes the serial command decoder gives one-cycle word strobes on sys_clk_i.
`timescale 1ns/1ps
module cal5_regs
	import cal5_regs_pkg::*;
(
	input  wire logic               sys_clk_i,
	input  wire logic               rst_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	input  wire logic        [5:0]  reg_addr_i,
	input  wire logic        [15:0] reg_wdata_i,
	output logic             [15:0] reg_rdata_o,
	output logic                    reg_hit_o,
	input  wire logic        [15:0] map_checksum_i,
	input  wire logic               sample_valid_i,
	input  wire logic signed [23:0] sample_i,
	output logic             [23:0] offset_coef_o,
	output logic             [23:0] gain_coef_o,
	output logic                    result_valid_o,
	output logic signed      [23:0] result_o
);
	// ****************************************
	// Storage
	// ****************************************
	logic [15:0] chan5_offset_high_field_q;
	logic [7:0]  chan5_offset_low_field_q;
	logic [15:0] chan5_gain_high_field_q;
	logic [7:0]  chan5_gain_low_field_q;
	logic [15:0] reserved_word_q;
	logic [15:0] rdata_d;

	wire logic sel_off_up  = reg_addr_i == ADDR_OFFSET_UPPER;
	wire logic sel_off_lo  = reg_addr_i == ADDR_OFFSET_LOWER;
	wire logic sel_gain_up = reg_addr_i == ADDR_GAIN_UPPER;
	wire logic sel_gain_lo = reg_addr_i == ADDR_GAIN_LOWER;
	wire logic sel_crc     = reg_addr_i == ADDR_MAP_CHECKSUM;
	wire logic sel_rsv     = reg_addr_i == ADDR_RESERVED_WORD;

	assign reg_hit_o = sel_off_up | sel_off_lo | sel_gain_up | sel_gain_lo | sel_crc | sel_rsv;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			chan5_offset_high_field_q <= RST_OFFSET_UPPER;                 // see R1
			chan5_offset_low_field_q  <= RST_OFFSET_LOW;                   // see R2
			chan5_gain_high_field_q   <= RST_GAIN_UPPER;                   // see R4
			chan5_gain_low_field_q    <= RST_GAIN_LOW;                     // see R5
			reserved_word_q           <= RST_RESERVED_WORD;
		end else if (reg_wr_i) begin
			if (sel_off_up)  chan5_offset_high_field_q <= reg_wdata_i;    // see R1
			if (sel_off_lo)  chan5_offset_low_field_q  <= reg_wdata_i[15:8]; // see R2
			if (sel_gain_up) chan5_gain_high_field_q   <= reg_wdata_i;    // see R4
			if (sel_gain_lo) chan5_gain_low_field_q    <= reg_wdata_i[15:8]; // see R5
			// Stored as written; the host owes zeros here, so nothing is enforced
			if (sel_rsv)     reserved_word_q           <= reg_wdata_i;    // see R8
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Lower words keep their byte on top; the bottom byte is tied off, never stored
	function automatic logic [15:0] lower_word(input logic [7:0] field);
		return {field, RESERVED_LOW_BITS};
	endfunction

	wire logic [15:0] off_lo_word  = lower_word(chan5_offset_low_field_q);        // see R3
	wire logic [15:0] gain_lo_word = lower_word(chan5_gain_low_field_q);          // see R3

	// Checksum is read live from the map hashing logic; writes to it are dropped
	assign rdata_d = sel_off_up  ? chan5_offset_high_field_q :
			 sel_off_lo  ? off_lo_word :
			 sel_gain_up ? chan5_gain_high_field_q :
			 sel_gain_lo ? gain_lo_word :
			 sel_crc     ? map_checksum_i :                                     // see R7
			 sel_rsv     ? reserved_word_q : 16'h0000;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_d;
		end
	end

	// ****************************************
	// Coefficient outputs
	// ****************************************
	assign offset_coef_o = {chan5_offset_high_field_q, chan5_offset_low_field_q};
	assign gain_coef_o   = {chan5_gain_high_field_q, chan5_gain_low_field_q};     // see R6

	// ****************************************
	// Correction datapath
	// ****************************************
	// Runs from the live coefficients, so a half-rewritten pair is applied until its partner lands
	cal5_corrector u_corrector (
		.sys_clk_i      (sys_clk_i),
		.rst_i          (rst_i),
		.sample_valid_i (sample_valid_i),
		.sample_i       (sample_i),
		.offset_i       ($signed(offset_coef_o)),
		.gain_i         (gain_coef_o),
		.result_valid_o (result_valid_o),
		.result_o       (result_o)
	);

	// ****************************************
	// Checks
	// ****************************************
	sequence s_write_gain_up;
		reg_wr_i && sel_gain_up;
	endsequence
	property p_gain_upper_reset;
		@(posedge sys_clk_i) rst_i |=> gain_coef_o == {RST_GAIN_UPPER, RST_GAIN_LOW};
	endproperty
	a_gain_upper_reset: assert property (p_gain_upper_reset) else $error("gain reset wrong"); // see R4
	property p_offset_reset;
		@(posedge sys_clk_i) rst_i |=> offset_coef_o == 24'h000000;
	endproperty
	a_offset_reset: assert property (p_offset_reset) else $error("offset reset wrong"); // see R1
	property p_offset_upper_write;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_off_up |=> offset_coef_o[23:8] == $past(reg_wdata_i);
	endproperty
	a_offset_upper_write: assert property (p_offset_upper_write) else $error("offset upper lost"); // see R1
	property p_offset_lower_write;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_off_lo |=> offset_coef_o[7:0] == $past(reg_wdata_i[15:8]);
	endproperty
	a_offset_lower_write: assert property (p_offset_lower_write) else $error("offset low lost"); // see R2
	property p_lower_reserved_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && (sel_off_lo || sel_gain_lo) |=> reg_rdata_o[7:0] == 8'h00;
	endproperty
	a_lower_reserved_zero: assert property (p_lower_reserved_zero) else $error("reserved bits set"); // see R3
	property p_gain_upper_write;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_write_gain_up |=> gain_coef_o[23:8] == $past(reg_wdata_i);
	endproperty
	a_gain_upper_write: assert property (p_gain_upper_write) else $error("gain upper lost"); // see R4
	property p_gain_lower_write;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_gain_lo |=> gain_coef_o[7:0] == $past(reg_wdata_i[15:8]);
	endproperty
	a_gain_lower_write: assert property (p_gain_lower_write) else $error("gain low lost"); // see R5
	property p_checksum_read;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && sel_crc |=> reg_rdata_o == $past(map_checksum_i);
	endproperty
	a_checksum_read: assert property (p_checksum_read) else $error("checksum read wrong"); // see R7
	property p_reserved_reset;
		@(posedge sys_clk_i) rst_i |=> reserved_word_q == RST_RESERVED_WORD;
	endproperty
	a_reserved_reset: assert property (p_reserved_reset) else $error("reserved word reset wrong"); // see R8
	property p_checksum_write_ignored;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_crc |=> $stable(offset_coef_o) && $stable(gain_coef_o) && $stable(reserved_word_q);
	endproperty
	a_checksum_write_ignored: assert property (p_checksum_write_ignored) else $error("checksum write took effect"); // see R7
	property p_offset_upper_no_spill;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_off_up |=> $stable(offset_coef_o[7:0]);
	endproperty
	a_offset_upper_no_spill: assert property (p_offset_upper_no_spill) else $error("offset low moved"); // see R1
	property p_offset_low_no_spill;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_off_lo |=> $stable(offset_coef_o[23:8]);
	endproperty
	a_offset_low_no_spill: assert property (p_offset_low_no_spill) else $error("offset upper moved"); // see R2
	property p_gain_upper_no_spill;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_gain_up |=> $stable(gain_coef_o[7:0]);
	endproperty
	a_gain_upper_no_spill: assert property (p_gain_upper_no_spill) else $error("gain low moved"); // see R4
	property p_gain_low_no_spill;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && sel_gain_lo |=> $stable(gain_coef_o[23:8]);
	endproperty
	a_gain_low_no_spill: assert property (p_gain_low_no_spill) else $error("gain upper moved"); // see R5
	property p_offset_upper_read;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && sel_off_up |=> reg_rdata_o == $past(offset_coef_o[23:8]);
	endproperty
	a_offset_upper_read: assert property (p_offset_upper_read) else $error("offset upper read wrong"); // see R1
	property p_offset_lower_read;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && sel_off_lo |=> reg_rdata_o[15:8] == $past(offset_coef_o[7:0]);
	endproperty
	a_offset_lower_read: assert property (p_offset_lower_read) else $error("offset low read wrong"); // see R2
	property p_gain_upper_read;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && sel_gain_up |=> reg_rdata_o == $past(gain_coef_o[23:8]);
	endproperty
	a_gain_upper_read: assert property (p_gain_upper_read) else $error("gain upper read wrong"); // see R4
	property p_gain_lower_read;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && sel_gain_lo |=> reg_rdata_o[15:8] == $past(gain_coef_o[7:0]);
	endproperty
	a_gain_lower_read: assert property (p_gain_lower_read) else $error("gain low read wrong"); // see R5
	property p_reserved_read;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && sel_rsv |=> reg_rdata_o == $past(reserved_word_q);
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved word read wrong"); // see R8
	property p_result_latency;
		@(posedge sys_clk_i) disable iff (rst_i)
		sample_valid_i |=> result_valid_o;
	endproperty
	a_result_latency: assert property (p_result_latency) else $error("result late"); // see R9

	// ****************************************
	// Result stream
	// ****************************************
	property p_result_idle;
		@(posedge sys_clk_i) disable iff (rst_i)
		!sample_valid_i |=> !result_valid_o;
	endproperty
	a_result_idle: assert property (p_result_idle) else $error("result valid without sample"); // see R9
	property p_result_holds;
		@(posedge sys_clk_i) disable iff (rst_i)
		!sample_valid_i |=> $stable(result_o);
	endproperty
	a_result_holds: assert property (p_result_holds) else $error("result changed without sample"); // see R9
endmodule // cal5_regs

// >>> verif/host_model.sv
// Host register master for the channel-5 calibration slice.
// Assumes one-cycle word strobes sampled on the rising clock edge.
`timescale 1ns/1ps
module host_model (
	input  wire logic        sys_clk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic        hit_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [5:0]  addr_o,
	output logic      [15:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 6'h00;
		wdata_o = 16'h0000;
	end

	// Released lines flip so a stale value can never pass for a match
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= (a == 6'h3f) ? 16'h0000 : d;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~wdata_o;
	endtask

	task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic h);
		@(posedge sys_clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		#1 h = hit_i;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask
endmodule // host_model

// >>> verif/testbench.sv
// Self-checking bench for the channel-5 calibration register slice.
// Assumes host_model drives the register strobes; bench drives samples.
`timescale 1ns/1ps
module testbench;
	import cal5_regs_pkg::*;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, sample_valid_i = 1'b0, wr, rd, hit, vld;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, cks = 16'h5a3c, d;
	logic h;
	logic signed [23:0] sample_i = 24'h000000, res;
	logic [23:0] ofs, gain;
	int error_cnt = 0, check_count = 0, cyc = 0;

	initial forever #12.5 sys_clk_i = ~sys_clk_i;

	host_model u_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .hit_i(hit), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wdata));
	cal5_regs u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit), .map_checksum_i(cks),
		.sample_valid_i(sample_valid_i), .sample_i(sample_i), .offset_coef_o(ofs), .gain_coef_o(gain),
		.result_valid_o(vld), .result_o(res));

	task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic rchk(input logic [5:0] a, input logic [15:0] e, input logic eh);
		u_host.rd(a, d, h);
		chk("rdata", {8'h00, d}, {8'h00, e});
		chk("hit", {23'h0, h}, {23'h0, eh});
	endtask

	task automatic smp(input logic signed [23:0] s, input logic [23:0] e);
		@(posedge sys_clk_i);
		sample_valid_i <= 1'b1;
		sample_i <= s;
		@(posedge sys_clk_i);
		sample_valid_i <= 1'b0;
		sample_i <= ~s;
		#1 chk("valid", {23'h0, vld}, 24'h000001);
		chk("result", res, e);
	endtask

	task automatic summarize();
		$display("mismatches %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		// ****************************************
		// Reset values and access kinds
		// ****************************************
		rchk(ADDR_OFFSET_UPPER, RST_OFFSET_UPPER, 1'b1);
		rchk(ADDR_OFFSET_LOWER, 16'h0000, 1'b1);
		rchk(ADDR_GAIN_UPPER, RST_GAIN_UPPER, 1'b1);
		rchk(ADDR_GAIN_LOWER, 16'h0000, 1'b1);
		rchk(ADDR_MAP_CHECKSUM, 16'h5a3c, 1'b1);
		rchk(ADDR_RESERVED_WORD, 16'h0000, 1'b1);
		rchk(6'h10, 16'h0000, 1'b0);
		u_host.wr(ADDR_OFFSET_UPPER, 16'ha5c3);
		u_host.wr(ADDR_OFFSET_LOWER, 16'hffff);
		u_host.wr(ADDR_GAIN_UPPER, 16'h1234);
		u_host.wr(ADDR_GAIN_LOWER, 16'habcd);
		u_host.wr(ADDR_MAP_CHECKSUM, 16'hffff);
		u_host.wr(ADDR_RESERVED_WORD, 16'h7777);
		rchk(ADDR_OFFSET_LOWER, 16'hff00, 1'b1);
		rchk(ADDR_GAIN_LOWER, 16'hab00, 1'b1);
		rchk(ADDR_MAP_CHECKSUM, 16'h5a3c, 1'b1);
		rchk(ADDR_RESERVED_WORD, 16'h0000, 1'b1);
		chk("offset", ofs, 24'ha5c3ff);
		chk("gain", gain, 24'h1234ab);
		@(posedge sys_clk_i);
		cks <= 16'hc3a5;
		rchk(ADDR_MAP_CHECKSUM, 16'hc3a5, 1'b1);
		// ****************************************
		// Correction of samples
		// ****************************************
		u_host.wr(ADDR_OFFSET_UPPER, 16'h0000);
		u_host.wr(ADDR_OFFSET_LOWER, 16'h1000);
		u_host.wr(ADDR_GAIN_UPPER, 16'h8000);
		u_host.wr(ADDR_GAIN_LOWER, 16'h0000);
		smp(24'sd100, 24'd84);
		u_host.wr(ADDR_GAIN_UPPER, 16'h4000);
		smp(-24'sd100, -24'sd58);
		u_host.wr(ADDR_GAIN_UPPER, 16'hc000);
		smp(24'sd100, 24'd126);
		// Mid-run reset must restore the coefficients, after which unity gain passes samples through
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rchk(ADDR_GAIN_UPPER, RST_GAIN_UPPER, 1'b1);
		rchk(ADDR_OFFSET_LOWER, 16'h0000, 1'b1);
		smp(-24'sd100, -24'sd100);
		summarize();
	end
endmodule // testbench
